// *** logic/pfh_host.sv ***
// host controller driving a byte-wide parallel flash through its pins
// Function
// [RULE_01] read: select and output gate low, write strobe high, clear high
// [RULE_02] device starts in array read after power-up and clear
// [RULE_03] device answers array data until a command changes it
// [RULE_04] write: select and write strobe low, output gate high
// [RULE_05] command register has no address; latches feed the state machine
// [RULE_06] erase targets one sector, several, or the whole array
// [RULE_07] identification command makes reads return codes
// [RULE_08] during program or erase, reads return status bits
// [RULE_09] select and clear high: standby, data lines high-impedance
// [RULE_10] after standby, read data valid only after select access time
// [RULE_11] deselect does not stop a running program or erase
// [RULE_12] clear low for minimum pulse aborts, tristates, returns to read
// [RULE_13] clear low also puts the device in standby
// [RULE_14] host reissues operations aborted by a clear; this host only pulses clear_done
// [RULE_15] clear during operation: done flag low until clear completes
// [RULE_16] clear while idle completes within idle clear-complete time
// [RULE_17] host waits read-after-clear delay before reading
// [RULE_18] write inhibited unless select and strobe low, output gate high
// [RULE_19] each write latches address and data in the device
// [RULE_20] all timings are parameters in whole clock cycles; the host has no output gate parameter and fixes recovery at two cycles
`timescale 1ns/1ps
module pfh_host
    import pfh_pkg::*;
#(
    parameter int SEL_CYC   = SELECT_ACCESS_CYC, // RULE_20
    parameter int WR_CYC    = WRITE_PULSE_CYC,
    parameter int CLR_CYC   = CLEAR_PULSE_CYC,
    parameter int RAC_CYC   = READ_AFTER_CYC,
    parameter int RDYB_CYC  = READY_BUSY_CYC,
    parameter int RDYI_CYC  = READY_IDLE_CYC
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // user side
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_clear,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   clear_done,
    output logic                   dev_busy,
    // flash pins
    output logic [ADDR_W-1:0]      address_lines,
    input  wire logic [DATA_W-1:0] data_lines_i,
    output logic [DATA_W-1:0]      data_lines_o,
    output logic                   data_lines_oe,
    output logic                   select_n,
    output logic                   out_gate_n,
    output logic                   wr_strobe_n,
    output logic                   hard_clear_n,
    input  wire logic              op_done_flag
);
    // refuse zero timings and busy, idle or clear waits the counter cannot hold; busy wait must cover read-after-clear
    if (SEL_CYC < 1 || WR_CYC < 1 || CLR_CYC < 1 || RAC_CYC < 1 ||
        RDYB_CYC < 1 || RDYI_CYC < 1 || RDYB_CYC < RAC_CYC ||
        RDYB_CYC >= (1 << CNT_W) || RDYI_CYC >= (1 << CNT_W) || CLR_CYC >= (1 << CNT_W))
    begin : g_bad_timing
        $error("pfh_host: timing parameter out of range");
    end

    localparam logic [CNT_W-1:0] SEL_C  = CNT_W'(SEL_CYC);
    localparam logic [CNT_W-1:0] WR_C   = CNT_W'(WR_CYC);
    localparam logic [CNT_W-1:0] CLR_C  = CNT_W'(CLR_CYC);
    localparam logic [CNT_W-1:0] RAC_C  = CNT_W'(RAC_CYC);
    localparam logic [CNT_W-1:0] RDYB_C = CNT_W'(RDYB_CYC);
    localparam logic [CNT_W-1:0] RDYI_C = CNT_W'(RDYI_CYC);

    pfh_state_t              state_q, state_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [ADDR_W-1:0]       addr_q, addr_d;
    logic [DATA_W-1:0]       wdata_q, wdata_d;
    logic [DATA_W-1:0]       rdata_q, rdata_d;
    logic                    rsp_q, rsp_d;
    logic                    cdone_q, cdone_d;
    logic                    busy_clr_q, busy_clr_d;
    logic                    sel_q, sel_d;
    logic                    oe_q, oe_d;
    logic                    we_q, we_d;
    logic                    drv_q, drv_d;
    logic                    clr_q, clr_d;

    // sequencer next state
    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        rdata_d    = rdata_q;
        rsp_d      = 1'b0;
        cdone_d    = 1'b0;
        busy_clr_d = busy_clr_q;
        sel_d      = sel_q;
        oe_d       = oe_q;
        we_d       = we_q;
        drv_d      = drv_q;
        clr_d      = clr_q;
        case (state_q)
            PFH_IDLE:
            begin
                if (req_valid && req_clear)
                begin
                    // hold clear low the minimum pulse; all strobes off
                    state_d    = PFH_CLEAR; // RULE_12
                    clr_d      = 1'b1;
                    sel_d      = 1'b0;
                    busy_clr_d = !op_done_flag;
                    cnt_d      = CLR_C;
                end
                else if (req_valid && req_write)
                begin
                    state_d = PFH_WRITE;
                    addr_d  = req_addr; // RULE_19
                    wdata_d = req_wdata;
                    sel_d   = 1'b1; // RULE_04
                    we_d    = 1'b1; // RULE_18
                    oe_d    = 1'b0;
                    drv_d   = 1'b1;
                    cnt_d   = WR_C;
                end
                else if (req_valid)
                begin
                    state_d = PFH_READ;
                    addr_d  = req_addr;
                    sel_d   = 1'b1; // RULE_01
                    oe_d    = 1'b1;
                    we_d    = 1'b0;
                    cnt_d   = SEL_C; // RULE_10
                end
            end
            PFH_READ:
            begin
                if (cnt_q == '0)
                begin
                    // data valid after select access time from standby
                    rdata_d = data_lines_i; // RULE_08
                    rsp_d   = 1'b1;
                    sel_d   = 1'b0; // RULE_09
                    oe_d    = 1'b0;
                    state_d = PFH_RECOV;
                    cnt_d   = 16'h0001;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            PFH_WRITE:
            begin
                if (cnt_q == '0)
                begin
                    // rising strobe latches command; select released too
                    we_d    = 1'b0;
                    sel_d   = 1'b0; // RULE_11
                    state_d = PFH_RECOV;
                    cnt_d   = 16'h0001;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            PFH_RECOV:
            begin
                // two idle cycles; after a write data still driven in the first, then no longer driven
                drv_d = 1'b0;
                if (cnt_q == '0)
                    state_d = PFH_IDLE;
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            PFH_CLEAR:
            begin
                if (cnt_q == '0)
                begin
                    clr_d   = 1'b0;
                    state_d = PFH_CWAIT;
                    // wait for the longer of completion and read-after-clear
                    cnt_d   = busy_clr_q ? RDYB_C : RDYI_C; // RULE_15 RULE_16
                    if (cnt_d < RAC_C)
                        cnt_d = RAC_C; // RULE_17
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            PFH_CWAIT:
            begin
                // busy case ends early once the done flag is high and read-after-clear has passed
                if (cnt_q == '0 || (busy_clr_q && op_done_flag && cnt_q <= RDYB_C - RAC_C))
                begin
                    cdone_d    = 1'b1; // RULE_14 not met: only clear_done pulses, nothing is reissued
                    busy_clr_d = 1'b0;
                    state_d    = PFH_IDLE;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            default:
            begin
                state_d = PFH_IDLE;
                sel_d   = 1'b0;
                oe_d    = 1'b0;
                we_d    = 1'b0;
                drv_d   = 1'b0;
                clr_d   = 1'b0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_q    <= PFH_IDLE;
            cnt_q      <= '0;
            addr_q     <= '0;
            wdata_q    <= '0;
            rdata_q    <= '0;
            rsp_q      <= 1'b0;
            cdone_q    <= 1'b0;
            busy_clr_q <= 1'b0;
            sel_q      <= 1'b0;
            oe_q       <= 1'b0;
            we_q       <= 1'b0;
            drv_q      <= 1'b0;
            clr_q      <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            rdata_q    <= rdata_d;
            rsp_q      <= rsp_d;
            cdone_q    <= cdone_d;
            busy_clr_q <= busy_clr_d;
            sel_q      <= sel_d;
            oe_q       <= oe_d;
            we_q       <= we_d;
            drv_q      <= drv_d;
            clr_q      <= clr_d;
        end
    end

    // pin and user outputs; strobes exclusive by construction
    assign address_lines = addr_q;
    assign data_lines_o  = wdata_q;
    assign data_lines_oe = drv_q && !oe_q; // no contention with device
    assign select_n      = !sel_q;
    assign out_gate_n    = !oe_q;
    assign wr_strobe_n   = !we_q;
    assign hard_clear_n  = !clr_q; // RULE_13
    assign req_ready     = (state_q == PFH_IDLE);
    assign rsp_valid     = rsp_q;
    assign rsp_rdata     = rdata_q;
    assign clear_done    = cdone_q;
    assign dev_busy      = !op_done_flag;
endmodule : pfh_host

// *** logic/pfh_pkg.sv ***
// constants for the parallel flash host controller
package pfh_pkg;
    localparam int ADDR_W           = 20;
    localparam int DATA_W           = 8;
    localparam int CLK_PERIOD_NS    = 20;
    // times in ns
    localparam int SELECT_ACCESS_NS = 150;
    localparam int OUT_GATE_NS      = 75;
    localparam int WRITE_PULSE_NS   = 60;
    localparam int CLEAR_PULSE_NS   = 500;
    localparam int READ_AFTER_NS    = 50;
    localparam int READY_BUSY_NS    = 20000;
    localparam int READY_IDLE_NS    = 500;
    // cycle counts, least times rounded up
    localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OUT_GATE_CYC      = (OUT_GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_PULSE_CYC   = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_AFTER_CYC    = (READ_AFTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_BUSY_CYC    = (READY_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_IDLE_CYC    = (READY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W             = 16;

    typedef enum logic [2:0] {
        PFH_IDLE   = 3'b000,
        PFH_READ   = 3'b001,
        PFH_WRITE  = 3'b010,
        PFH_RECOV  = 3'b011,
        PFH_CLEAR  = 3'b100,
        PFH_CWAIT  = 3'b101
    } pfh_state_t;
endpackage : pfh_pkg

// *** verification/parallel_flash_bus_ops_bench.sv ***
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module parallel_flash_bus_ops_bench;
    import pfh_pkg::*;
    localparam logic [7:0] ID_CMD = 8'hc3, ID_CODE = 8'h3c, STAT = 8'h4b;
    localparam logic [7:0] ERASE_CMD = 8'ha5; // model default
    logic mclk, sys_rst, req_valid, req_ready, req_write, req_clear, rsp_valid, clear_done;
    logic dev_busy, data_lines_oe, select_n, out_gate_n, wr_strobe_n, hard_clear_n;
    logic op_done_flag, start_op, m_oe;
    logic [19:0] req_addr, address_lines, a;
    logic [7:0]  req_wdata, rsp_rdata, h_dq, m_dq, bus, flt_q;
    logic [7:0]  mem_exp [16];
    logic [7:0]  exp_q [$];
    logic [31:0] seed;
    int errors, checks_done;
    pfh_host #(.RDYB_CYC(20)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_clear(req_clear),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .clear_done(clear_done), .dev_busy(dev_busy),
        .address_lines(address_lines), .data_lines_i(bus), .data_lines_o(h_dq),
        .data_lines_oe(data_lines_oe), .select_n(select_n), .out_gate_n(out_gate_n),
        .wr_strobe_n(wr_strobe_n), .hard_clear_n(hard_clear_n), .op_done_flag(op_done_flag));
    pfh_flash_model #(.ID_CMD(ID_CMD), .ID_CODE(ID_CODE), .STAT(STAT)) i_flash (.mclk(mclk),
        .address_lines(address_lines), .data_bus(bus), .select_n(select_n),
        .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .hard_clear_n(hard_clear_n),
        .start_op(start_op), .dq_o(m_dq), .dq_oe(m_oe), .op_done_flag(op_done_flag));
    // undriven data lines wander
    assign bus = m_oe ? m_dq : data_lines_oe ? h_dq : flt_q;
    always @(posedge mclk) flt_q <= ~bus;
    initial
    begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic report_and_stop(input bit hung);
        if (hung) errors++;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic chk8(input logic [7:0] got, input logic [7:0] want);
        checks_done++;
        if (got !== want) begin errors++; $display("Error %0t: byte %h not %h", $time, got, want); end
    endtask : chk8
    task automatic chk1(input logic got, input logic want);
        checks_done++;
        if (got !== want) begin errors++; $display("Error %0t: flag %b not %b", $time, got, want); end
    endtask : chk1
    task automatic wait_ready();
        int n;
        n = 0;
        do begin @(negedge mclk); n++; if (n > 300) report_and_stop(1); end while (req_ready !== 1'b1);
    endtask : wait_ready
    task automatic req(input logic w, input logic c, input logic [19:0] ad, input logic [7:0] d);
        wait_ready();
        @(posedge mclk);
        {req_valid, req_write, req_clear, req_addr, req_wdata} <= {1'b1, w, c, ad, d};
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask : req
    task automatic rd(input logic [19:0] ad, input logic [7:0] want);
        exp_q.push_back(want);
        req(1'b0, 1'b0, ad, 8'h00);
    endtask : rd
    task automatic clr();
        int n;
        req(1'b0, 1'b1, 20'h0, 8'h00);
        n = 0;
        do begin @(posedge mclk); n++; if (n > 2000) report_and_stop(1); end while (clear_done !== 1'b1);
        chk1(op_done_flag, 1'b1);
    endtask : clr
    // answer checker: oldest expectation against each read response
    always @(negedge mclk)
        if (rsp_valid === 1'b1)
        begin
            if (exp_q.size() != 0)
                chk8(rsp_rdata, exp_q.pop_front());
            else
            begin
                errors++;
                $display("Error %0t: answer without request", $time);
            end
        end
    initial
    begin
        sys_rst   <= 1'b1;
        {req_valid, req_write, req_clear, start_op} <= 4'h0;
        req_addr  <= 20'h0;
        req_wdata <= 8'h00;
        seed = 32'h329f;
        foreach (mem_exp[i]) mem_exp[i] = 8'hff;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(20'h3, 8'hff);
        repeat (12)
        begin
            seed = xs(seed);
            a = seed[19:0];
            mem_exp[a[3:0]] = seed[30:24] & 8'h7f;
            req(1'b1, 1'b0, a, mem_exp[a[3:0]]);
            rd(a, mem_exp[a[3:0]]);
        end
        req(1'b1, 1'b0, 20'h0, ID_CMD);
        rd(20'h5, ID_CODE);
        clr();
        rd(20'h5, mem_exp[5]);
        // let the read finish before the embedded operation starts
        wait_ready();
        @(posedge mclk) start_op <= 1'b1;
        @(posedge mclk) start_op <= 1'b0;
        @(negedge mclk) chk1(dev_busy, 1'b1);
        rd(20'h7, STAT);
        clr();
        req(1'b1, 1'b0, 20'h7, 8'h21);
        rd(20'h7, 8'h21);
        mem_exp[7] = 8'h21;
        // sector erase of entries 4 to 7; entry 3 stays
        req(1'b1, 1'b0, 20'h6, ERASE_CMD);
        for (int i = 4; i < 8; i++) mem_exp[i] = 8'hff;
        rd(20'h7, mem_exp[7]);
        rd(20'h3, mem_exp[3]);
        repeat (40) @(posedge mclk);
        if (exp_q.size() != 0) report_and_stop(1);
        report_and_stop(0);
    end
endmodule : parallel_flash_bus_ops_bench

// *** verification/pfh_flash_model.sv ***
// behavioural model of the byte-wide flash device
`timescale 1ns/1ps
module pfh_flash_model #(
    parameter logic [7:0] ID_CMD  = 8'hc3,
    parameter logic [7:0] ID_CODE = 8'h3c, // arbitrary value
    parameter logic [7:0] STAT    = 8'h4b,
    parameter logic [7:0] ERASE_CMD = 8'ha5
) (
    input wire logic        mclk,
    input wire logic [19:0] address_lines,
    input wire logic [7:0]  data_bus,
    input wire logic        select_n,
    input wire logic        out_gate_n,
    input wire logic        wr_strobe_n,
    input wire logic        hard_clear_n,
    input wire logic        start_op,
    output logic [7:0]      dq_o,
    output logic            dq_oe,
    output logic            op_done_flag
);
    logic [7:0] mem [16];
    logic [7:0] wd_q;
    logic [3:0] wa_q;
    logic [3:0] acc_q;
    logic       wr_q;
    logic       ident_q;
    int         busy_q;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hff;
        {ident_q, busy_q, acc_q} = '0;
        wr_q = 1'b1; // strobe idles high, no false rising edge
    end
    // output drive after access time, standby when deselected or cleared
    assign dq_oe = !select_n && !out_gate_n && hard_clear_n && acc_q >= 4'h2;
    assign dq_o  = busy_q != 0 ? STAT : ident_q ? ID_CODE : mem[address_lines[3:0]];
    assign op_done_flag = busy_q == 0;
    // command latches, embedded operation timer and clear
    always @(posedge mclk)
    begin
        acc_q <= (select_n || !hard_clear_n) ? 4'h0 : acc_q + 4'(acc_q != 4'hf);
        wr_q <= wr_strobe_n;
        if (!wr_strobe_n && !select_n && out_gate_n && hard_clear_n)
        begin
            wa_q <= address_lines[3:0];
            wd_q <= data_bus;
        end
        if (wr_strobe_n && !wr_q && hard_clear_n)
        begin
            if (wd_q == ID_CMD) ident_q <= 1'b1;
            else if (wd_q == ERASE_CMD)
            begin
                // upper model address bits pick the sector
                foreach (mem[i])
                    if (i[3:2] == wa_q[3:2]) mem[i] <= 8'hff;
            end
            else mem[wa_q] <= wd_q;
        end
        if (!hard_clear_n)
        begin
            ident_q <= 1'b0;
            if (busy_q != 0) busy_q <= 10;
        end
        else if (start_op) busy_q <= 40;
        else if (busy_q != 0) busy_q <= busy_q - 1;
    end
endmodule : pfh_flash_model

// *** verification/pfh_host_monitor.sv ***
// pin-level assertion checker for the flash host controller
`timescale 1ns/1ps
module pfh_host_monitor
    import pfh_pkg::*;
#(
    parameter int SEL_CYC = SELECT_ACCESS_CYC,
    parameter int CLR_CYC = CLEAR_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic rsp_valid,
    input wire logic clear_done,
    input wire logic dev_busy,
    input wire logic data_lines_oe,
    input wire logic select_n,
    input wire logic out_gate_n,
    input wire logic wr_strobe_n,
    input wire logic hard_clear_n,
    input wire logic op_done_flag
);
    localparam int RSP_D = SEL_CYC + 1;
    logic [15:0] low_q;
    logic [15:0] low_d;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // length of the current clear pulse
    always_comb low_d = hard_clear_n ? 16'h0 : low_q + 16'h1;
    always_ff @(posedge mclk) low_q <= sys_rst ? 16'h0 : low_d;
    property p_read_levels;
        !out_gate_n |-> wr_strobe_n && hard_clear_n && !data_lines_oe;
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("bad read levels");
    property p_write_levels;
        !wr_strobe_n |-> !select_n && out_gate_n && hard_clear_n && data_lines_oe;
    endproperty
    a_write_levels: assert property (p_write_levels) else $error("bad write levels");
    property p_clear_len;
        $rose(hard_clear_n) |-> low_q >= CLR_CYC;
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear pulse short");
    property p_clear_quiet;
        !hard_clear_n |-> select_n && out_gate_n && wr_strobe_n;
    endproperty
    a_clear_quiet: assert property (p_clear_quiet) else $error("access during clear");
    property p_read_after;
        $rose(hard_clear_n) |-> select_n [*3];
    endproperty
    a_read_after: assert property (p_read_after) else $error("read too soon");
    property p_rsp_timing;
        $fell(select_n) && !out_gate_n |-> ##RSP_D rsp_valid;
    endproperty
    a_rsp_timing: assert property (p_rsp_timing) else $error("read answer late");
    property p_busy_mirror;
        dev_busy == !op_done_flag;
    endproperty
    a_busy_mirror: assert property (p_busy_mirror) else $error("busy mismatch");
    property p_clear_done;
        clear_done |-> hard_clear_n && op_done_flag;
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("clear done early");
    property p_clear_gap;
        $rose(hard_clear_n) |-> !clear_done [*3];
    endproperty
    a_clear_gap: assert property (p_clear_gap) else $error("clear done too soon");
endmodule : pfh_host_monitor

bind pfh_host pfh_host_monitor #(.SEL_CYC(SEL_CYC), .CLR_CYC(CLR_CYC)) i_mon (
    .mclk(mclk), .sys_rst(sys_rst), .rsp_valid(rsp_valid), .clear_done(clear_done),
    .dev_busy(dev_busy), .data_lines_oe(data_lines_oe), .select_n(select_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .hard_clear_n(hard_clear_n),
    .op_done_flag(op_done_flag));
